// File: logic/rie_pkg.sv
// radio interrupt-enable set register: shared constants and types
// assumes a 12-bit byte address and a 32-bit data path on the register port

package rie_pkg;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int RIE_ADDR_W = 12;
  localparam int RIE_DATA_W = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [RIE_ADDR_W-1:0] RIE_OFS_ENABLE_SET = 12'h304;
  localparam logic [RIE_ADDR_W-1:0] RIE_OFS_STATUS     = 12'h400;
  localparam logic [RIE_ADDR_W-1:0] RIE_OFS_PENDING    = 12'h404;

  // ----------------------------------------------------------------
  // field positions, shared by enable, status and pending
  // ----------------------------------------------------------------
  localparam int RIE_POS_ENERGY_DETECT_STOPPED  = 16;
  localparam int RIE_POS_CHANNEL_ASSESS_IDLE    = 17;
  localparam int RIE_POS_CHANNEL_ASSESS_BUSY    = 18;
  localparam int RIE_POS_CHANNEL_ASSESS_STOPPED = 19;
  localparam int RIE_POS_RATE_SWITCH_EVENT      = 20;
  localparam int RIE_POS_TRANSMIT_READY_EVENT   = 21;
  localparam int RIE_POS_RECEIVE_READY_EVENT    = 22;
  localparam int RIE_POS_HEADER_MATCH_EVENT     = 23;
  localparam int RIE_POS_PREAMBLE_SYNC_EVENT    = 26;
  localparam int RIE_POS_PHY_END_EVENT          = 27;
  localparam int RIE_POS_TONE_EXTENSION_PRESENT = 28;

  // implemented bits; all others read as zero
  localparam logic [RIE_DATA_W-1:0] RIE_FIELD_MASK = 32'h1cff_0000;
  localparam logic [RIE_DATA_W-1:0] RIE_RESET_VAL  = 32'h0000_0000;
  localparam logic [RIE_DATA_W-1:0] RIE_READ_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // radio modes and preamble watcher states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_other           = 2'h0,
    long_range_125k_mode = 2'h1,
    long_range_500k_mode = 2'h2,
    low_rate_250k_mode   = 2'h3
  } rie_mode_t;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_listen = 2'b01,
    st_hit    = 2'b11
  } rie_sync_state_t;

endpackage

// File: logic/rie_flag_bit.sv
// one sticky flag: set wins over clear, frozen while ce is low except that rst still clears it
// assumes set and clr are from logic on clk

`timescale 1ns/1ps

module rie_flag_bit
  import rie_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule

// File: logic/rie_sync_watch.sv
// preamble watcher: turns a raw preamble hint into a one-cycle event
// assumes hint, rx_active and mode come from radio logic on clk

`timescale 1ns/1ps

module rie_sync_watch
  import rie_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  input  wire logic      rx_active,
  input  wire rie_mode_t mode,
  input  wire logic      preamble_hint,
  output logic           sync_pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rie_sync_state_t state;
  rie_sync_state_t next_state;
  logic            mode_ok;

  assign mode_ok = (mode == long_range_125k_mode) ||
                   (mode == long_range_500k_mode) ||
                   (mode == low_rate_250k_mode);

  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (rx_active && mode_ok) begin
          next_state = st_listen;
        end
      end
      st_listen: begin
        if (!(rx_active && mode_ok)) begin
          next_state = st_idle;
        end else if (preamble_hint) begin
          next_state = st_hit;
        end
      end
      st_hit: begin
        next_state = (rx_active && mode_ok) ? st_listen : st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= st_idle;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // one cycle per hint; spurious hints pass through by design
  assign sync_pulse = (state == st_hit);

endmodule

// File: logic/rie_top.sv
// radio interrupt-enable set register with sticky event status
// assumes events, clears and the register port all run on clk

`timescale 1ns/1ps

// Behaviour
// RQ1: writing 1 enables energy detect stopped interrupt until cleared elsewhere
// RQ2: writing 1 enables the channel assessment idle interrupt
// RQ3: writing 1 enables the channel assessment busy interrupt
// RQ4: writing 1 enables the channel assessment stopped interrupt
// RQ5: writing 1 enables the rate boost interrupt
// RQ6: writing 1 enables the transmitter ready interrupt
// RQ7: writing 1 enables the receiver ready interrupt
// RQ8: writing 1 enables the header match interrupt
// RQ9: writing 1 enables the preamble sync interrupt
// RQ10: preamble sync raised in long range or low rate modes; spurious allowed
// RQ11: writing 1 enables the end of packet interrupt
// RQ12: writing 1 enables the tone extension present interrupt
// RQ13: reading an enable field returns one when enabled, else zero
// RQ14: writing zero leaves an enable unchanged
module rie_top
  import rie_pkg::*;
#(
  parameter int ADDR_W = RIE_ADDR_W,
  parameter int DATA_W = RIE_DATA_W
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [DATA_W-1:0] enable_clear,
  input  wire logic              energy_detect_stopped,
  input  wire logic              channel_assess_idle,
  input  wire logic              channel_assess_busy,
  input  wire logic              channel_assess_stopped,
  input  wire logic              rate_switch_event,
  input  wire logic              transmit_ready_event,
  input  wire logic              receive_ready_event,
  input  wire logic              header_match_event,
  input  wire logic              rx_active,
  input  wire rie_mode_t         radio_mode,
  input  wire logic              preamble_hint,
  input  wire logic              phy_end_event,
  input  wire logic              tone_extension_present,
  output logic      [DATA_W-1:0] enable_out,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  logic wr_enable_set;
  logic wr_status;

  assign wr_enable_set = reg_wr && addr_is(reg_addr, RIE_OFS_ENABLE_SET);
  assign wr_status     = reg_wr && addr_is(reg_addr, RIE_OFS_STATUS);

  // ----------------------------------------------------------------
  // preamble sync event
  // ----------------------------------------------------------------
  logic preamble_sync_event;

  // RQ10: mode-qualified preamble event
  rie_sync_watch u_sync (
    .clk           (clk),
    .rst           (rst),
    .ce            (ce),
    .rx_active     (rx_active),
    .mode          (radio_mode),
    .preamble_hint (preamble_hint),
    .sync_pulse    (preamble_sync_event)
  );

  // ----------------------------------------------------------------
  // event vector in register layout
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] event_vec;

  always_comb begin
    event_vec = RIE_RESET_VAL;
    event_vec[RIE_POS_ENERGY_DETECT_STOPPED]  = energy_detect_stopped;
    event_vec[RIE_POS_CHANNEL_ASSESS_IDLE]    = channel_assess_idle;
    event_vec[RIE_POS_CHANNEL_ASSESS_BUSY]    = channel_assess_busy;
    event_vec[RIE_POS_CHANNEL_ASSESS_STOPPED] = channel_assess_stopped;
    event_vec[RIE_POS_RATE_SWITCH_EVENT]      = rate_switch_event;
    event_vec[RIE_POS_TRANSMIT_READY_EVENT]   = transmit_ready_event;
    event_vec[RIE_POS_RECEIVE_READY_EVENT]    = receive_ready_event;
    event_vec[RIE_POS_HEADER_MATCH_EVENT]     = header_match_event;
    event_vec[RIE_POS_PREAMBLE_SYNC_EVENT]    = preamble_sync_event;
    event_vec[RIE_POS_PHY_END_EVENT]          = phy_end_event;
    event_vec[RIE_POS_TONE_EXTENSION_PRESENT] = tone_extension_present;
  end

  // ----------------------------------------------------------------
  // enable set strobes, one per field
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] enable_set_vec;
  logic [DATA_W-1:0] enable_clr_vec;

  // RQ14: only ones in the write data set
  assign enable_set_vec = wr_enable_set ? reg_wdata : RIE_RESET_VAL;
  // RQ1: clears come only from outside this register
  assign enable_clr_vec = enable_clear;

  // ----------------------------------------------------------------
  // storage: enable and sticky status per implemented bit
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] enable;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] status_clr_vec;

  // status bits are write-one-to-clear; a same-cycle event wins
  assign status_clr_vec = wr_status ? reg_wdata : RIE_RESET_VAL;

  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_bit
      if (RIE_FIELD_MASK[gi]) begin : g_used
        // RQ2: per-field write one to set
        rie_flag_bit u_enable (
          .clk (clk),
          .rst (rst),
          .ce  (ce),
          .set (enable_set_vec[gi]),
          .clr (enable_clr_vec[gi]),
          .q   (enable[gi])
        );
        rie_flag_bit u_status (
          .clk (clk),
          .rst (rst),
          .ce  (ce),
          .set (event_vec[gi]),
          .clr (status_clr_vec[gi]),
          .q   (status[gi])
        );
      end else begin : g_unused
        assign enable[gi] = 1'b0;
        assign status[gi] = 1'b0;
      end
    end
  endgenerate

  // RQ3: busy enable via field mask bit
  // RQ4: stopped enable via field mask bit
  // RQ5: rate boost enable via field mask bit
  // RQ6: transmit ready via field mask bit
  // RQ7: receive ready via field mask bit
  // RQ8: header match via field mask bit
  // RQ9: preamble sync via field mask bit
  // RQ11: end of packet via field mask bit
  // RQ12: tone extension via field mask bit
  // (the generate above covers each of these positions)

  // ----------------------------------------------------------------
  // interrupt line
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] pending;

  // enable register doubles as the mask
  assign pending = status & enable;
  assign irq     = |pending;

  // radio side sees the live enables
  assign enable_out = enable;

  // ----------------------------------------------------------------
  // read port: data in the cycle after the strobe
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  // RQ13: enable reads back as stored
  always_comb begin
    next_rdata = RIE_READ_ZERO;
    if (addr_is(reg_addr, RIE_OFS_ENABLE_SET)) begin
      next_rdata = enable;
    end else if (addr_is(reg_addr, RIE_OFS_STATUS)) begin
      next_rdata = status;
    end else if (addr_is(reg_addr, RIE_OFS_PENDING)) begin
      next_rdata = pending;
    end
  end

  // read data held only one cycle while ce is high; with ce low reg_rdata keeps its value
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= RIE_READ_ZERO;
    end else if (ce) begin
      reg_rdata <= reg_rd ? next_rdata : RIE_READ_ZERO;
    end
  end

endmodule

// File: dv/rie_top_sva.sv
// checker for the enable-set register, watching top ports only
// assumes one clk domain, synchronous rst, rie_pkg constants

`timescale 1ns/1ps

module rie_top_sva
  import rie_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic [RIE_ADDR_W-1:0] reg_addr,
  input wire logic [RIE_DATA_W-1:0] reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [RIE_DATA_W-1:0] reg_rdata,
  input wire logic [RIE_DATA_W-1:0] enable_clear,
  input wire logic                  energy_detect_stopped,
  input wire logic                  rx_active,
  input wire rie_mode_t             radio_mode,
  input wire logic                  preamble_hint,
  input wire logic [RIE_DATA_W-1:0] enable_out,
  input wire logic                  irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic wr_ens;
  logic good;
  assign wr_ens = ce && reg_wr && (reg_addr == RIE_OFS_ENABLE_SET);
  // hint only counts after a cycle of receive in a listed mode
  assign good = ce && rx_active && (radio_mode != mode_other);

  sequence s_pre;
    good ##1 (good && preamble_hint)
      ##1 (ce && enable_out[26] && !enable_clear[26]);
  endsequence

  AST_SET: assert property (wr_ens |=>
    ((enable_out & $past(reg_wdata) & RIE_FIELD_MASK)
      == ($past(reg_wdata) & RIE_FIELD_MASK)))
    else $error("enable bit not set by write");
  AST_KEEP: assert property (ce && enable_clear == '0 |=>
    (($past(enable_out) & ~enable_out) == '0))
    else $error("enable dropped without clear");
  AST_NOSET: assert property (ce && !wr_ens |=>
    ((enable_out & ~$past(enable_out)) == '0))
    else $error("enable rose without write");
  AST_CLR: assert property (ce && !wr_ens |=>
    ((enable_out & $past(enable_clear)) == '0))
    else $error("enable survived clear");
  AST_RD: assert property (
    ce && reg_rd && reg_addr == RIE_OFS_ENABLE_SET
      |=> reg_rdata == $past(enable_out))
    else $error("read data differs from enables");
  AST_RD_IDLE: assert property (ce && !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero when idle");
  AST_RSVD: assert property ((enable_out & ~RIE_FIELD_MASK) == '0)
    else $error("reserved enable bit set");
  AST_EVT: assert property (
    ce && energy_detect_stopped && enable_out[16] && !enable_clear[16]
      |=> irq)
    else $error("enabled event gave no irq");
  AST_PRE: assert property (s_pre |=> irq)
    else $error("preamble hint gave no irq");
  AST_NOIRQ: assert property (enable_out == '0 |-> !irq)
    else $error("irq with all enables off");

  cover property (wr_ens);
  cover property (s_pre);
  cover property ($rose(irq));
endmodule

bind rie_top rie_top_sva i_sva (.clk, .rst, .ce, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .enable_clear, .energy_detect_stopped,
  .rx_active, .radio_mode, .preamble_hint, .enable_out, .irq);

// File: dv/rie_top_test.sv
// testbench for the enable-set register and its event status
// assumes rie_top with default widths, driven on rising clk

`timescale 1ns/1ps

module rie_top_test
  import rie_pkg::*;
;
  logic        clk, rst, ce, reg_wr, reg_rd, rx_active, preamble_hint;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, enable_clear, ev, reg_rdata, enable_out;
  logic [31:0] rd_v, exp_v;
  logic        irq;
  rie_mode_t   radio_mode;
  int          err_count, checks_done;

  rie_top i_dut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .enable_clear,
    .energy_detect_stopped(ev[16]), .channel_assess_idle(ev[17]),
    .channel_assess_busy(ev[18]), .channel_assess_stopped(ev[19]),
    .rate_switch_event(ev[20]), .transmit_ready_event(ev[21]),
    .receive_ready_event(ev[22]), .header_match_event(ev[23]),
    .rx_active, .radio_mode, .preamble_hint, .phy_end_event(ev[27]),
    .tone_extension_present(ev[28]), .enable_out, .irq);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic pulse(input logic [31:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard; run needs well under this
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, ce} = 2'b11;
    {reg_wr, reg_rd, rx_active, preamble_hint} = '0;
    {reg_addr, reg_wdata, enable_clear, ev} = '0;
    radio_mode = mode_other;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(RIE_OFS_ENABLE_SET, rd_v);
    cmp32(rd_v, RIE_RESET_VAL);
    wr(RIE_OFS_ENABLE_SET, ~RIE_FIELD_MASK);
    rd(RIE_OFS_ENABLE_SET, rd_v);
    cmp32(rd_v, RIE_READ_ZERO);
    rd(12'h308, rd_v);
    cmp32(rd_v, RIE_READ_ZERO);
    cmp1(irq, 1'b0);
    $display("test reset done");
    exp_v = '0;
    for (int i = 0; i < 32; i++) begin
      if (RIE_FIELD_MASK[i]) begin
        wr(RIE_OFS_ENABLE_SET, 32'h1 << i);
        exp_v |= 32'h1 << i;
        rd(RIE_OFS_ENABLE_SET, rd_v);
        cmp32(rd_v, exp_v);
        wr(RIE_OFS_ENABLE_SET, '0);
        cmp32(enable_out, exp_v);
      end
    end
    $display("test set done");
    @(posedge clk);
    enable_clear <= 32'h1 << 16;
    @(posedge clk);
    enable_clear <= '0;
    #1 cmp32(enable_out, RIE_FIELD_MASK & ~(32'h1 << 16));
    // masked event stays sticky until enabled
    pulse(32'h1 << 16);
    cmp1(irq, 1'b0);
    rd(RIE_OFS_STATUS, rd_v);
    cmp32(rd_v, 32'h1 << 16);
    wr(RIE_OFS_ENABLE_SET, 32'h1 << 16);
    cmp1(irq, 1'b1);
    wr(RIE_OFS_STATUS, 32'h1 << 16);
    $display("test clear done");
    for (int i = 0; i < 32; i++) begin
      if (RIE_FIELD_MASK[i] && i != 26) begin
        pulse(32'h1 << i);
        cmp1(irq, 1'b1);
        rd(RIE_OFS_PENDING, rd_v);
        cmp32(rd_v, 32'h1 << i);
        wr(RIE_OFS_STATUS, 32'h1 << i);
        cmp1(irq, 1'b0);
      end
    end
    $display("test events done");
    // ce low must freeze status, clears and events alike
    pulse(32'h1 << 17);
    @(posedge clk);
    ce <= 1'b0;
    wr(RIE_OFS_STATUS, 32'h1 << 17);
    pulse(32'h1 << 18);
    cmp1(irq, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    rd(RIE_OFS_PENDING, rd_v);
    cmp32(rd_v, 32'h1 << 17);
    wr(RIE_OFS_STATUS, 32'h1 << 17);
    cmp1(irq, 1'b0);
    $display("test freeze done");
    // mode 0 is not a listed mode: its hint must be ignored
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      rx_active <= 1'b1;
      radio_mode <= rie_mode_t'(m);
      @(posedge clk);
      preamble_hint <= 1'b1;
      @(posedge clk);
      preamble_hint <= 1'b0;
      @(posedge clk);
      #1 cmp1(irq, m != 0);
      wr(RIE_OFS_STATUS, 32'h1 << 26);
      cmp1(irq, 1'b0);
      @(posedge clk);
      rx_active <= 1'b0;
    end
    $display("test preamble done");
    // reset in mid-run drops enables and pending status
    pulse(32'h1 << 19);
    cmp1(irq, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 cmp32(enable_out, RIE_RESET_VAL);
    cmp1(irq, 1'b0);
    rd(RIE_OFS_PENDING, rd_v);
    cmp32(rd_v, RIE_READ_ZERO);
    $display("test reset again done");
    finish_test;
  end
endmodule
